// ### hdl/emb_bus_ctrl.sv
// Contract
// - Data width 8 or 16 bits; address width up to 20 bits.
// - 28 shared pins: 20 address/data lines plus eight control strobes.
// - Lines 0-15 carry address then data; lines 16-19 address only. With 8-bit data, lines 8-15 carry address only.
// - Eight strobes: latch, output enable, two writes, byte lsb, chip, byte selects.
// - Internal-only mode disables the control register and ignores writes.
// - Release bit clear: pins are the bus permanently, port functions off.
// - Release bit set: pins are ports; bus takes them during accesses.
// - Control register resets to zero, bus permanently enabled.
// - Wait field 11/10/01/00 adds 0/1/2/3 instruction cycles.
// - Word write mode outputs latch word, high write strobe on high byte.
// - Byte select mode copies byte to both halves, high write plus byte select.
// - Byte write mode copies byte to both halves, high or low write.
// - Write mode has no effect with 8-bit data width.
// - Control and timer period register share one address, chosen by map bit.
// - Data width bit set gives 16 bits, clear gives 8 bits.
// - Two-bit strap selects 20/16/12-bit address or internal-only.
// - Narrower address width returns unused high lines to port use.
// - Address and data always time-multiplexed; latch strobe marks address.
// - Unimplemented control bits ignore writes and read zero.
// - Wait cycles only when wait strap set, after the access cycle.
// - Idle bus: lines tri-stated, enables high, latch and byte lsb low.
//
// Implementation choices: the APB slave port and the register addresses.
module emb_bus_ctrl
  import emb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_width_cfg,
  input wire logic [1:0] address_width_cfg,
  input wire logic wait_cfg_en,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire emb_req_t acc_req,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  input wire logic [19:0] port_out,
  input wire logic [19:0] port_oe,
  input wire logic [7:0] port_ctl_out,
  input wire logic [7:0] port_ctl_oe,
  input wire logic [15:0] ad_in,
  output logic [19:0] ad_out,
  output logic [19:0] ad_oe,
  output emb_ctrl_t ctl_out,
  output logic [7:0] ctl_oe
);

  emb_state_t s;
  emb_state_t next_s;

  // Lines that the strapped address width hands to the bus
  function automatic logic [19:0] width_mask(input emb_aw_t aw);
    unique case (aw)
      EMB_AW20: width_mask = 20'hFFFFF;
      EMB_AW16: width_mask = 20'h0FFFF;
      EMB_AW12: width_mask = 20'h00FFF;
      EMB_INT_ONLY: width_mask = 20'h00000;
    endcase
  endfunction

  // Extra strobe cycles from the wait field
  function automatic logic [3:0] wait_clks(input logic en, input logic [1:0] sel);
    logic [1:0] tcy;
    tcy = EMB_WAIT_NONE - sel;
    wait_clks = en ? 4'(tcy * EMB_TCY_CLKS) : 4'h0;
  endfunction

  emb_aw_t aw;
  logic int_only;
  logic wide;
  logic [1:0] wm;
  logic [19:0] mask;
  logic busy;
  logic own;
  logic mapped;
  logic [19:0] addr_v;
  logic [15:0] wdata_v;
  logic [19:0] bus_out;
  logic [19:0] bus_oe;
  emb_ctrl_t bus_ctl;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.aw_s1 = address_width_cfg;
    next_s.aw_s2 = s.aw_s1;
    next_s.dw_s1 = data_width_cfg;
    next_s.dw_s2 = s.dw_s1;
    next_s.wen_s1 = wait_cfg_en;
    next_s.wen_s2 = s.wen_s1;
    next_s.din_s1 = ad_in;
    next_s.din_s2 = s.din_s1;

    aw = emb_aw_t'(s.aw_s2);
    int_only = (aw == EMB_INT_ONLY);
    wide = s.dw_s2;
    wm = wide ? s.ctrl[EMB_WM_LSB +: 2] : 2'b00;
    mask = width_mask(aw);
    busy = (s.st != EMB_IDLE);

    mapped = (paddr == EMB_OFF_CTRL) || (paddr == EMB_OFF_WDT)
      || (paddr == EMB_OFF_STAT);

    // Read data registered in the setup cycle, stable in access
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        EMB_OFF_CTRL: next_s.prdata = {24'h000000, s.alt ? s.ctrl : s.period};
        EMB_OFF_WDT: next_s.prdata = {31'h00000000, s.alt};
        EMB_OFF_STAT: next_s.prdata = {26'h0000000, s.release_eff, busy,
          s.wen_s2, s.dw_s2, s.aw_s2};
        default: next_s.prdata = 32'h00000000;
      endcase
    end

    if (psel && penable && pwrite) begin
      if (paddr == EMB_OFF_CTRL) begin
        if (!s.alt) begin
          next_s.period = pwdata[7:0];
        end else if (!int_only) begin
          next_s.ctrl = pwdata[7:0] & EMB_CTRL_MASK;
        end
      end else if (paddr == EMB_OFF_WDT) begin
        next_s.alt = pwdata[EMB_ALT_BIT];
      end
    end

    unique case (s.st)
      EMB_IDLE: begin
        // Release change waits for the bus to be quiet
        next_s.release_eff = s.ctrl[EMB_REL_BIT];
        if (acc_valid) begin
          next_s.req = acc_req;
          if (int_only) begin
            next_s.rdata = 16'h0000;
            next_s.done = 1'b1;
          end else if (acc_req.write && wm[1] && !acc_req.addr[0]) begin
            // Low byte only fills the latch; the high byte fires the word
            next_s.hold_lo = acc_req.wdata;
            next_s.done = 1'b1;
          end else begin
            next_s.st = EMB_ADDR;
          end
        end
      end
      EMB_ADDR: next_s.st = EMB_LATCH;
      EMB_LATCH: begin
        next_s.st = EMB_DATA;
        next_s.cnt = 4'(EMB_DATA_CLKS - 4'h1
          + wait_clks(s.wen_s2, s.ctrl[EMB_WAIT_LSB +: 2]));
      end
      EMB_DATA: begin
        if (s.cnt == 4'h0) begin
          next_s.st = EMB_END;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      EMB_END: begin
        // Data phase outlasts the input synchroniser delay
        next_s.rdata = wide ? s.din_s2 : {8'h00, s.din_s2[7:0]};
        next_s.done = 1'b1;
        next_s.st = EMB_IDLE;
      end
      default: next_s.st = EMB_IDLE;
    endcase

    addr_v = wide ? s.req.addr[20:1] : s.req.addr[19:0];
    if (!wide) begin
      wdata_v = {addr_v[15:8], s.req.wdata};
    end else if (wm[1]) begin
      wdata_v = {s.req.wdata, s.hold_lo};
    end else begin
      wdata_v = {s.req.wdata, s.req.wdata};
    end

    bus_out = 20'h00000;
    bus_oe = 20'h00000;
    bus_ctl = EMB_CTRL_IDLE;
    if (busy) begin
      bus_ctl.ce_n = 1'b0;
      bus_out = addr_v;
      bus_oe = mask;
      bus_ctl.ale = (s.st == EMB_ADDR);
      bus_ctl.ba0 = (!wide || wm == 2'b01) && s.req.addr[0];
      if (s.st == EMB_DATA || s.st == EMB_END) begin
        if (s.req.write) begin
          bus_out[15:0] = wdata_v;
        end else begin
          bus_oe[15:0] = wide ? 16'h0000 : {mask[15:8], 8'h00};
        end
      end
      if (s.st == EMB_DATA) begin
        if (!s.req.write) begin
          bus_ctl.oe_n = 1'b0;
        end else if (!wide) begin
          bus_ctl.wrl_n = 1'b0;
        end else if (wm[1]) begin
          bus_ctl.wrh_n = 1'b0;
        end else if (wm == 2'b01) begin
          bus_ctl.wrh_n = 1'b0;
          bus_ctl.ub_n = !s.req.addr[0];
          bus_ctl.lb_n = s.req.addr[0];
        end else begin
          bus_ctl.wrh_n = !s.req.addr[0];
          bus_ctl.wrl_n = s.req.addr[0];
        end
      end
    end

    // Outside internal-only mode the bus owns pins always when not released, else only while busy
    own = !int_only && (!s.release_eff || busy);
    for (int i = 0; i < 20; i++) begin
      next_s.ad_out[i] = (own && mask[i]) ? bus_out[i] : port_out[i];
      next_s.ad_oe[i] = (own && mask[i]) ? bus_oe[i] : port_oe[i];
    end
    next_s.ctl_out = own ? bus_ctl : emb_ctrl_t'(port_ctl_out);
    next_s.ctl_oe = own ? 8'hFF : port_ctl_oe;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= EMB_IDLE;
      s.ctrl <= EMB_CTRL_RESET;
      s.period <= EMB_PERIOD_RESET;
      s.dw_s1 <= 1'b1;
      s.dw_s2 <= 1'b1;
      s.aw_s1 <= EMB_INT_ONLY;
      s.aw_s2 <= EMB_INT_ONLY;
      s.ctl_out <= EMB_CTRL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign acc_ready = (s.st == EMB_IDLE);
  assign acc_done = s.done;
  assign acc_rdata = s.rdata;
  assign ad_out = s.ad_out;
  assign ad_oe = s.ad_oe;
  assign ctl_out = s.ctl_out;
  assign ctl_oe = s.ctl_oe;

endmodule // emb_bus_ctrl

// ### hdl/emb_pkg.sv
package emb_pkg;
  localparam logic [11:0] EMB_OFF_CTRL = 12'h000;
  localparam logic [11:0] EMB_OFF_WDT = 12'h004;
  localparam logic [11:0] EMB_OFF_STAT = 12'h008;
  localparam logic [7:0] EMB_CTRL_RESET = 8'h00;
  localparam logic [7:0] EMB_CTRL_MASK = 8'hB3;
  localparam logic [7:0] EMB_PERIOD_RESET = 8'hFF;
  localparam int EMB_REL_BIT = 7;
  localparam int EMB_WAIT_LSB = 4;
  localparam int EMB_WM_LSB = 0;
  localparam int EMB_ALT_BIT = 0;
  localparam logic [3:0] EMB_TCY_CLKS = 4'h4;
  localparam logic [3:0] EMB_DATA_CLKS = 4'h3;
  localparam logic [1:0] EMB_WAIT_NONE = 2'h3;

  typedef enum logic [1:0] {
    EMB_AW20 = 2'b00,
    EMB_AW16 = 2'b01,
    EMB_AW12 = 2'b10,
    EMB_INT_ONLY = 2'b11
  } emb_aw_t;

  typedef enum logic [4:0] {
    EMB_IDLE = 5'b00001,
    EMB_ADDR = 5'b00010,
    EMB_LATCH = 5'b00100,
    EMB_DATA = 5'b01000,
    EMB_END = 5'b10000
  } emb_st_t;

  typedef struct packed {
    logic ub_n;
    logic lb_n;
    logic ce_n;
    logic ba0;
    logic wrh_n;
    logic wrl_n;
    logic oe_n;
    logic ale;
  } emb_ctrl_t;

  // Idle: enables and write strobes high, latch strobe and byte lsb low
  localparam emb_ctrl_t EMB_CTRL_IDLE = 8'hEE;

  typedef struct packed {
    logic write;
    logic [20:0] addr;
    logic [7:0] wdata;
  } emb_req_t;

  typedef struct packed {
    emb_st_t st;
    logic [7:0] ctrl;
    logic [7:0] period;
    logic alt;
    logic [31:0] prdata;
    logic release_eff;
    logic [3:0] cnt;
    emb_req_t req;
    logic [7:0] hold_lo;
    logic done;
    logic [15:0] rdata;
    logic [1:0] aw_s1;
    logic [1:0] aw_s2;
    logic dw_s1;
    logic dw_s2;
    logic wen_s1;
    logic wen_s2;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic [19:0] ad_out;
    logic [19:0] ad_oe;
    emb_ctrl_t ctl_out;
    logic [7:0] ctl_oe;
  } emb_state_t;
endpackage

// ### testbench/emb_mem_model.sv
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic pclk,
  input wire logic [19:0] ad_out,
  input wire logic [19:0] ad_oe,
  input wire emb_ctrl_t ctl_out,
  output logic [15:0] ad_in,
  output logic [15:0] last_wdata,
  output emb_ctrl_t last_wctl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] lat = '0;
  logic [15:0] held = '0;
  logic [15:0] rd;
  // Released lines show the inverse of the last level, so stale data cannot pass
  assign rd = (!ctl_out.oe_n && !ctl_out.ce_n) ? {8'hC3, lat[7:0]} : ~held;
  assign ad_in = (ad_oe[15:0] & ad_out[15:0]) | (~ad_oe[15:0] & rd);
  always @(posedge pclk) begin
    held <= ad_in;
    if (ctl_out.ale) lat <= ad_out;
    if (!ctl_out.wrl_n || !ctl_out.wrh_n) begin
      last_wdata <= ad_out[15:0];
      last_wctl <= ctl_out;
    end
  end
endmodule // emb_mem_model

// ### testbench/emb_bus_ctrl_assertions.sv
module emb_bus_ctrl_chk
  import emb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] address_width_cfg,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic [19:0] port_oe,
  input wire logic [7:0] port_ctl_oe,
  input wire logic [19:0] ad_oe,
  input wire emb_ctrl_t ctl_out,
  input wire logic [7:0] ctl_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_idle;
    acc_ready && $past(acc_ready) && ctl_oe == 8'hFF |-> ctl_out == EMB_CTRL_IDLE;
  endproperty
  property p_ale_pulse;
    ctl_oe == 8'hFF && $rose(ctl_out.ale) |=> !ctl_out.ale;
  endproperty
  property p_ale_strb;
    ctl_oe == 8'hFF && ctl_out.ale
      |-> ctl_out.oe_n && ctl_out.wrl_n && ctl_out.wrh_n && !ctl_out.ce_n;
  endproperty
  property p_ale_drv;
    ctl_oe == 8'hFF && ctl_out.ale |-> ad_oe[7:0] == 8'hFF;
  endproperty
  property p_rd_rel;
    ctl_oe == 8'hFF && !ctl_out.oe_n |-> ad_oe[7:0] == 8'h00;
  endproperty
  property p_oe_len;
    ctl_oe == 8'hFF && $past(ctl_oe) == 8'hFF && $fell(ctl_out.oe_n) |-> !ctl_out.oe_n [*3];
  endproperty
  property p_done;
    acc_done |=> !acc_done;
  endproperty
  property p_aw16;
    $past(presetn, 3) && address_width_cfg == EMB_AW16 && $past(address_width_cfg, 3) == EMB_AW16
      |-> ad_oe[19:16] == $past(port_oe[19:16]);
  endproperty
  property p_int;
    $past(presetn, 3) && address_width_cfg == EMB_INT_ONLY
      && $past(address_width_cfg, 3) == EMB_INT_ONLY
      |-> ctl_oe == $past(port_ctl_oe) && ad_oe == $past(port_oe);
  endproperty
  a_idle: assert property (p_idle) else $error("idle strobes wrong");
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch pulse too long");
  a_ale_strb: assert property (p_ale_strb) else $error("strobe during address");
  a_ale_drv: assert property (p_ale_drv) else $error("address not driven");
  a_rd_rel: assert property (p_rd_rel) else $error("lines driven in read");
  a_oe_len: assert property (p_oe_len) else $error("read strobe short");
  a_done: assert property (p_done) else $error("done not a pulse");
  a_aw16: assert property (p_aw16) else $error("upper lines not port");
  a_int: assert property (p_int) else $error("pins not port");
  c_rd: cover property ($fell(ctl_out.oe_n));
  c_wr: cover property ($fell(ctl_out.wrh_n));
  c_rel: cover property (acc_ready && ctl_oe != 8'hFF);
endmodule // emb_bus_ctrl_chk

bind emb_bus_ctrl emb_bus_ctrl_chk i_chk (.pclk, .presetn, .address_width_cfg, .acc_ready,
  .acc_done, .port_oe, .port_ctl_oe, .ad_oe, .ctl_out, .ctl_oe);

// ### testbench/test_emb_bus_ctrl.sv
module test_emb_bus_ctrl
  import emb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic data_width_cfg, wait_cfg_en, acc_valid, acc_ready, acc_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] address_width_cfg;
  emb_req_t acc_req;
  logic [15:0] acc_rdata, ad_in, mw;
  logic [19:0] port_out, port_oe, ad_out, ad_oe;
  logic [7:0] port_ctl_out, port_ctl_oe, ctl_oe;
  emb_ctrl_t ctl_out, mc;
  int n_mismatch = 0;
  int tests_run = 0;
  int lat, base;
  emb_bus_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .data_width_cfg, .address_width_cfg, .wait_cfg_en, .acc_valid,
    .acc_ready, .acc_req, .acc_done, .acc_rdata, .port_out, .port_oe, .port_ctl_out,
    .port_ctl_oe, .ad_in, .ad_out, .ad_oe, .ctl_out, .ctl_oe);
  emb_mem_model i_mem (.pclk, .ad_out, .ad_oe, .ctl_out, .ad_in, .last_wdata(mw),
    .last_wctl(mc));
  always #20 pclk = ~pclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    end_sim();
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Answer sampled mid-cycle, as it stands at the next rising edge
    do begin
      @(negedge pclk);
      rdy = pready;
      r = prdata;
      err = pslverr;
      @(posedge pclk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) give_up();
  endtask
  task automatic acc(input logic w, input logic [20:0] a, input logic [7:0] d);
    int k;
    logic rdy;
    acc_valid <= 1'b1;
    acc_req <= '{w, a, d};
    k = 0;
    do begin
      @(negedge pclk);
      rdy = acc_ready;
      @(posedge pclk);
      k++;
    end while (rdy !== 1'b1 && k < 99);
    acc_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge pclk);
      rdy = acc_done;
      @(posedge pclk);
      lat++;
    end while (rdy !== 1'b1 && lat < 99);
    if (k >= 99 || lat >= 99) give_up();
  endtask
  task automatic wchk(input logic [7:0] c, input logic [20:0] a, input logic [7:0] d,
      input logic [15:0] ew, input logic [1:0] es);
    apb(1'b1, EMB_OFF_CTRL, {24'h0, c});
    acc(1'b1, a, d);
    chk("wdata", mw, ew);
    chk("strobes", {mc.wrh_n, mc.wrl_n}, es);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, acc_valid} = '0;
    paddr = '0;
    pwdata = '0;
    acc_req = '0;
    {data_width_cfg, wait_cfg_en} = 2'b11;
    address_width_cfg = EMB_AW20;
    port_out = 20'h5A5A5;
    port_oe = 20'hF0F0F;
    port_ctl_out = 8'h3C;
    port_ctl_oe = 8'h0F;
    rst();
    apb(1'b1, EMB_OFF_WDT, 32'h1);
    apb(1'b0, EMB_OFF_CTRL, 32'h0);
    chk("ctrl", r, 32'h0);
    chk("ctl_oe", ctl_oe, 8'hFF);
    chk("ad_oe", ad_oe[15:0], 16'h0);
    apb(1'b1, EMB_OFF_CTRL, 32'hFF);
    apb(1'b0, EMB_OFF_CTRL, 32'h0);
    chk("mask", r, {24'h0, EMB_CTRL_MASK});
    apb(1'b1, EMB_OFF_WDT, 32'h0);
    apb(1'b0, EMB_OFF_CTRL, 32'h0);
    chk("period", r, {24'h0, EMB_PERIOD_RESET});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", err, 1'b1);
    apb(1'b1, EMB_OFF_WDT, 32'h1);
    for (int w = 3; w >= 0; w--) begin
      apb(1'b1, EMB_OFF_CTRL, 32'(w << 4));
      acc(1'b0, 21'h0024A, 8'h0);
      chk("rdata", acc_rdata, 16'hC325);
      if (w == 3) base = lat;
      chk("wait", lat - base, 4 * (3 - w));
    end
    wchk(8'h30, 21'h10, 8'h5C, 16'h5C5C, 2'b10);
    wchk(8'h30, 21'h11, 8'hA7, 16'hA7A7, 2'b01);
    wchk(8'h31, 21'h13, 8'h69, 16'h6969, 2'b01);
    chk("bsel", mc.ub_n ^ mc.lb_n, 1'b1);
    apb(1'b1, EMB_OFF_CTRL, 32'h32);
    acc(1'b1, 21'h20, 8'h34);
    wchk(8'h32, 21'h21, 8'h12, 16'h1234, 2'b01);
    apb(1'b1, EMB_OFF_CTRL, 32'hB0);
    repeat (3) @(posedge pclk);
    chk("rel_ctl", ctl_oe, port_ctl_oe);
    chk("rel_ad", ad_oe, port_oe);
    acc(1'b0, 21'h0024A, 8'h0);
    chk("rel_rd", acc_rdata, 16'hC325);
    // Straps pass the two-stage synchroniser every cycle; each strap case still starts from its own reset
    data_width_cfg <= 1'b0;
    address_width_cfg <= EMB_AW16;
    rst();
    apb(1'b1, EMB_OFF_WDT, 32'h1);
    wchk(8'h32, 21'h40, 8'h9E, 16'h009E, 2'b10);
    acc(1'b0, 21'h5B, 8'h0);
    chk("rd8", acc_rdata[7:0], 8'h5B);
    chk("aw16", ad_oe[19:16], port_oe[19:16]);
    address_width_cfg <= EMB_INT_ONLY;
    rst();
    apb(1'b1, EMB_OFF_WDT, 32'h1);
    apb(1'b1, EMB_OFF_CTRL, 32'hFF);
    apb(1'b0, EMB_OFF_CTRL, 32'h0);
    chk("int_ctrl", r, 32'h0);
    chk("int_pins", ad_oe, port_oe);
    end_sim();
  end
endmodule // test_emb_bus_ctrl
